// ### logic/interp_pkg.sv
/*
 * Constants of the interpolating zero-stuff datapath: word width, filter
 * taps, the midscale code and the sequencer states.
 * Assumes a single system clock that runs at the converter update rate.
 */
package interp_pkg;
   localparam int DATA_W = 14;
   localparam int COEF_W = 16;
   localparam int ACC_W = 34;
   localparam int TAPS = 43;
   localparam int HIST_LEN = 22;
   localparam int ODD_PAIRS = 11;
   localparam int CTR_IDX = 11;
   localparam int ODD_MID = 10;
   localparam int COEF_SHIFT = 14;
   localparam logic [ACC_W-1:0] ROUND_BIAS = 34'h000002000;
   localparam logic signed [ACC_W-1:0] SAT_MAX = 34'sh000001fff;
   localparam logic signed [ACC_W-1:0] SAT_MIN = -34'sh000002000;
   localparam logic [DATA_W-1:0] MIDSCALE = 14'h2000;
   localparam logic [DATA_W-1:0] RESET_WORD = 14'h2000;
   localparam logic signed [COEF_W-1:0] COEF_CENTER = 16'sh4000;
   // Odd-tap coefficients, nearest to the center first; Q15 half-band set.
   localparam logic signed [COEF_W-1:0] COEF_ODD [ODD_PAIRS] = '{
      16'sh286d, -16'sh0cf0, 16'sh0746, -16'sh04a6, 16'sh0320, -16'sh021c,
      16'sh0166, -16'sh00e2, 16'sh0085, -16'sh0046, 16'sh001c
   };
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CTR = 2'b01,
      ST_ODD = 2'b11,
      ST_MID = 2'b10
   } seq_state_e;
endpackage

// ### logic/word_buffer2.sv
/*
 * Two-entry word buffer with valid and ready on both sides.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module word_buffer2 (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [interp_pkg::DATA_W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [interp_pkg::DATA_W-1:0] out_data
);
   import interp_pkg::*;
   logic [DATA_W-1:0] mem_ff [2];
   logic [DATA_W-1:0] nxt_mem [2];
   logic wptr_ff, nxt_wptr, rptr_ff, nxt_rptr;
   logic [1:0] cnt_ff, nxt_cnt;
   logic push, pop;

   assign in_ready = (cnt_ff != 2'h2);
   assign out_valid = (cnt_ff != 2'h0);
   assign out_data = mem_ff[rptr_ff];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      nxt_mem = mem_ff;
      nxt_wptr = wptr_ff;
      nxt_rptr = rptr_ff;
      nxt_cnt = cnt_ff;
      if (push) begin
         nxt_mem[wptr_ff] = in_data;
         nxt_wptr = ~wptr_ff;
      end
      if (pop) begin
         nxt_rptr = ~rptr_ff;
      end
      if (push && !pop) begin
         nxt_cnt = cnt_ff + 2'h1;
      end else if (pop && !push) begin
         nxt_cnt = cnt_ff - 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mem_ff[0] <= RESET_WORD;
         mem_ff[1] <= RESET_WORD;
         wptr_ff <= 1'b0;
         rptr_ff <= 1'b0;
         cnt_ff <= 2'h0;
      end else begin
         mem_ff <= nxt_mem;
         wptr_ff <= nxt_wptr;
         rptr_ff <= nxt_rptr;
         cnt_ff <= nxt_cnt;
      end
   end
endmodule
`default_nettype wire

// ### logic/interp_zero_stuff_datapath.sv
/*
 * Two-times interpolating half-band filter with optional midscale stuffing.
 * Assumes SYS_CLK is the converter update clock, samples arrive from logic
 * on the same clock, and the two mode pins are static board straps.
 */
// Operation
// [R01] Two static mode pins pick filter response and stuffing independently.
// [R02] Filter is a 43-tap half-band FIR symmetric about its center tap.
// [R03] Response select low gives low-pass, high gives high-pass.
// [R04] Each input sample yields exactly two filtered output samples.
// [R05] Even taps other than the center are zero and need no multiplier.
// [R06] High-pass negates only the center coefficient, all others unchanged.
// [R07] Stuffing on inserts one midscale code after every filter output.
// [R08] A multiplexer alternates filter output and the midscale register.
// [R09] Stuffing off sends filter outputs straight on with nothing inserted.
// [R10] Best dynamic range wants a clean external clock at update rate.
// [R11] Samples are captured in input registers on the rising clock edge.
// [R12] All words are 14-bit offset binary.
// [R13] Output is rounded and saturated to 14 bits before the multiplexer.
`timescale 1ns/1ps
`default_nettype none
module interp_zero_stuff_datapath (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic FILTER_RESPONSE_SELECT,
   input wire logic ZERO_STUFF_ENABLE,
   input wire logic IN_VALID,
   output logic IN_READY,
   input wire logic [interp_pkg::DATA_W-1:0] IN_DATA,
   output logic OUT_VALID,
   input wire logic OUT_READY,
   output logic [interp_pkg::DATA_W-1:0] OUT_DATA
);
   import interp_pkg::*;

   // Offset binary to two's complement is a flip of the top bit.
   function automatic logic signed [DATA_W-1:0] to_signed(input logic [DATA_W-1:0] w);
      to_signed = {~w[DATA_W-1], w[DATA_W-2:0]};
   endfunction

   // Rounds the Q15 sum (with gain two) and clamps it to a 14-bit word.
   // The bias and the arithmetic shift round half up, for negative sums as well.
   function automatic logic [DATA_W-1:0] round_sat(input logic signed [ACC_W-1:0] acc);
      logic signed [ACC_W-1:0] r;
      r = (acc + $signed(ROUND_BIAS)) >>> COEF_SHIFT;
      if (r > SAT_MAX) begin
         r = SAT_MAX;
      end else if (r < SAT_MIN) begin
         r = SAT_MIN;
      end
      round_sat = {~r[DATA_W-1], r[DATA_W-2:0]};
   endfunction

   // Sign-extends a sample to accumulator width so no product is cut short.
   function automatic logic signed [ACC_W-1:0] widen(input logic [DATA_W-1:0] w);
      widen = ACC_W'(to_signed(w));
   endfunction

   // Mirrored taps share one multiplier: the two samples are summed first.
   function automatic logic signed [ACC_W-1:0] pair_sum(input logic [DATA_W-1:0] a,
      input logic [DATA_W-1:0] b);
      pair_sum = widen(a) + widen(b);
   endfunction

   // Picks the state after a filter word: midscale follows it when stuffing is on.
   function automatic seq_state_e after_filter(input logic stuff, input seq_state_e plain);
      after_filter = stuff ? ST_MID : plain;
   endfunction

   logic resp_meta_ff;
   logic resp_ff;
   logic stuff_meta_ff;
   logic stuff_ff;
   logic nxt_resp_meta;
   logic nxt_resp;
   logic nxt_stuff_meta;
   logic nxt_stuff;
   logic [DATA_W-1:0] nxt_mid_reg;
   logic [DATA_W-1:0] hist_ff [HIST_LEN];
   logic [DATA_W-1:0] nxt_hist [HIST_LEN];
   seq_state_e state_ff;
   seq_state_e nxt_state;
   logic after_ctr_ff;
   logic nxt_after_ctr;
   logic [DATA_W-1:0] mid_reg_ff;
   logic [DATA_W-1:0] ctr_word;
   logic [DATA_W-1:0] odd_word;
   logic [DATA_W-1:0] push_word;
   logic signed [ACC_W-1:0] ctr_acc;
   logic signed [ACC_W-1:0] odd_acc;
   logic signed [COEF_W-1:0] ctr_coef;
   logic push_valid;
   logic push_ready;
   logic take;

   // Mode straps come from board pins, so each passes two flops before use.
   always_comb begin
      nxt_resp_meta = FILTER_RESPONSE_SELECT;
      nxt_resp = resp_meta_ff;
      nxt_stuff_meta = ZERO_STUFF_ENABLE;
      nxt_stuff = stuff_meta_ff;
      nxt_mid_reg = MIDSCALE; // R07
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         resp_meta_ff <= 1'b0;
         resp_ff <= 1'b0;
         stuff_meta_ff <= 1'b0;
         stuff_ff <= 1'b0;
         mid_reg_ff <= MIDSCALE;
      end else begin
         resp_meta_ff <= nxt_resp_meta;
         resp_ff <= nxt_resp;
         stuff_meta_ff <= nxt_stuff_meta;
         stuff_ff <= nxt_stuff;
         mid_reg_ff <= nxt_mid_reg; // R07
      end
   end

   // Ready stays low for every word of a sample, so the history cannot shift
   // under a phase that is still waiting for room in the buffer.
   assign IN_READY = (state_ff == ST_IDLE);
   assign take = IN_VALID && IN_READY;

   // Input history at the data rate; entry zero is the newest sample.
   always_comb begin
      nxt_hist = hist_ff;
      if (take) begin
         nxt_hist[0] = IN_DATA; // R11
         for (int i = 1; i < HIST_LEN; i++) begin
            nxt_hist[i] = hist_ff[i-1];
         end
      end
   end

   // Only the center tap and the odd taps are multiplied; the rest are zero.
   // Both phase words are formed every cycle and the sequencer picks one.
   always_comb begin
      ctr_coef = resp_ff ? -COEF_CENTER : COEF_CENTER; // R03 R06
      ctr_acc = ACC_W'(ctr_coef) * widen(hist_ff[CTR_IDX]); // R05
      odd_acc = '0;
      for (int j = 0; j < ODD_PAIRS; j++) begin
         odd_acc = odd_acc + ACC_W'(COEF_ODD[j]) * pair_sum(hist_ff[ODD_MID-j],
            hist_ff[ODD_MID+1+j]); // R02 R05
      end
      ctr_word = round_sat(ctr_acc); // R13
      odd_word = round_sat(odd_acc); // R13
   end

   // Sequencer: center phase, odd phase, and midscale after each when stuffing.
   always_comb begin
      nxt_state = state_ff;
      nxt_after_ctr = after_ctr_ff;
      push_valid = 1'b0;
      push_word = mid_reg_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (take) begin
               nxt_state = ST_CTR;
            end
         end
         ST_CTR: begin
            push_valid = 1'b1;
            push_word = ctr_word; // R04
            if (push_ready) begin
               nxt_after_ctr = 1'b1;
               nxt_state = after_filter(stuff_ff, ST_ODD); // R01 R08 R09
            end
         end
         ST_MID: begin
            push_valid = 1'b1;
            push_word = mid_reg_ff; // R07 R08
            // The odd phase follows the center word; after the odd word the sample is done.
            if (push_ready) begin
               nxt_state = after_ctr_ff ? ST_ODD : ST_IDLE;
            end
         end
         ST_ODD: begin
            push_valid = 1'b1;
            push_word = odd_word; // R04
            if (push_ready) begin
               nxt_after_ctr = 1'b0;
               nxt_state = after_filter(stuff_ff, ST_IDLE); // R01 R09
            end
         end
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         for (int i = 0; i < HIST_LEN; i++) begin
            hist_ff[i] <= RESET_WORD; // R12
         end
      end else begin
         hist_ff <= nxt_hist; // R11
      end
   end

   // A mode strap change takes effect at the next phase decision, never inside a word.
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         state_ff <= ST_IDLE;
         after_ctr_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         after_ctr_ff <= nxt_after_ctr;
      end
   end

   // The two-entry buffer absorbs a receiver stall without losing a filter word.
   word_buffer2 u_out_buf (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .in_valid(push_valid),
      .in_ready(push_ready),
      .in_data(push_word),
      .out_valid(OUT_VALID),
      .out_ready(OUT_READY),
      .out_data(OUT_DATA)
   );
endmodule
`default_nettype wire

// ### tb/interp_zero_stuff_datapath_asserts.sv
/* Port checker for the interpolating datapath.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module interp_zero_stuff_datapath_asserts (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic FILTER_RESPONSE_SELECT,
   input wire logic ZERO_STUFF_ENABLE,
   input wire logic IN_VALID,
   input wire logic IN_READY,
   input wire logic [13:0] IN_DATA,
   input wire logic OUT_VALID,
   input wire logic OUT_READY,
   input wire logic [13:0] OUT_DATA
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   a_reset_idle_state: assert property ($rose(RST_N) |-> IN_READY && !OUT_VALID)
      else $error("datapath not idle after reset");
   a_take_drops_ready: assert property (IN_VALID && IN_READY |=> !IN_READY)
      else $error("ready stayed high after a take");
   a_two_words_plain: assert property (IN_VALID && IN_READY && !ZERO_STUFF_ENABLE |=> !IN_READY[*2])
      else $error("plain sample did not hold ready low two cycles");
   a_four_words_stuff: assert property (IN_VALID && IN_READY && ZERO_STUFF_ENABLE |=> !IN_READY[*4])
      else $error("stuffed sample did not hold ready low four cycles");
   a_output_soon: assert property (IN_VALID && IN_READY |-> ##[1:3] OUT_VALID)
      else $error("no output word after a take");
   a_stall_holds_word: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA))
      else $error("output word changed while stalled");
   a_valid_falls_pop: assert property ($fell(OUT_VALID) |-> $past(OUT_READY))
      else $error("output word vanished without a pop");
   a_stall_blocks_in: assert property ((IN_VALID && !OUT_READY)[*7] |-> !IN_READY)
      else $error("input still accepted with output stalled");
   a_ready_recovers: assert property (not (!IN_READY && OUT_READY)[*8])
      else $error("ready stuck low while output drains");
endmodule
bind interp_zero_stuff_datapath interp_zero_stuff_datapath_asserts i_chk (.SYS_CLK(SYS_CLK),
   .RST_N(RST_N), .FILTER_RESPONSE_SELECT(FILTER_RESPONSE_SELECT),
   .ZERO_STUFF_ENABLE(ZERO_STUFF_ENABLE), .IN_VALID(IN_VALID), .IN_READY(IN_READY),
   .IN_DATA(IN_DATA), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA));
`default_nettype wire

// ### tb/sample_source.sv
/* Sample source that feeds random words with a valid and ready handshake.
   Assumes the seed is set by the bench and inputs change at the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module sample_source (
   input wire logic clk,
   input wire logic en,
   input wire logic ready,
   output logic valid,
   output logic [13:0] data
);
   logic took = 1'b0;
   initial valid = 1'b0;
   initial data = 14'h0000;
   always @(posedge clk) took <= valid && ready;
   // A word is held until the rising edge that takes it; a released bus shows inverted bits.
   always @(negedge clk) begin
      if (took || !valid) begin
         valid <= en;
         data <= en ? 14'($urandom) : ~data;
      end
   end
endmodule
`default_nettype wire

// ### tb/tb_interp_zero_stuff_datapath.sv
/* Self-checking bench for the interpolating datapath in all four modes.
   Assumes the package constants and the checker bound to the design. */
`timescale 1ns/1ps
`default_nettype none
module tb_interp_zero_stuff_datapath;
   import interp_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, sel = 1'b0, zse = 1'b0, en = 1'b0, ordy = 1'b0;
   logic iv, ir, ov;
   logic [13:0] id, od;
   logic [13:0] exp_q[$];
   logic signed [33:0] hist[HIST_LEN];
   int miscompares = 0, tests_run = 0, cyc = 0;
   always #50 clk = ~clk;
   sample_source i_sample_source (.clk(clk), .en(en), .ready(ir), .valid(iv), .data(id));
   interp_zero_stuff_datapath i_interp_zero_stuff_datapath (.SYS_CLK(clk), .RST_N(rst_n),
      .FILTER_RESPONSE_SELECT(sel), .ZERO_STUFF_ENABLE(zse), .IN_VALID(iv), .IN_READY(ir),
      .IN_DATA(id), .OUT_VALID(ov), .OUT_READY(ordy), .OUT_DATA(od));
   function automatic logic [13:0] fir_word(input bit odd, input bit hp);
      logic signed [33:0] acc;
      acc = hp ? -hist[CTR_IDX] * COEF_CENTER : hist[CTR_IDX] * COEF_CENTER;
      if (odd) begin
         acc = 0;
         for (int j = 0; j < ODD_PAIRS; j++) begin
            acc += COEF_ODD[j] * (hist[ODD_MID-j] + hist[CTR_IDX+j]);
         end
      end
      acc = acc + ROUND_BIAS;
      acc = acc >>> COEF_SHIFT;
      if (acc > SAT_MAX) acc = SAT_MAX;
      if (acc < SAT_MIN) acc = SAT_MIN;
      return acc[13:0] ^ 14'h2000;
   endfunction
   task automatic check_word(input logic [13:0] got, input logic [13:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // The driving side notes expected words at each take.
   always @(posedge clk) begin
      if (rst_n && iv && ir) begin
         for (int i = HIST_LEN - 1; i > 0; i--) hist[i] = hist[i-1];
         hist[0] = {{21{~id[13]}}, id[12:0]};
         exp_q.push_back(fir_word(1'b0, sel));
         if (zse) exp_q.push_back(MIDSCALE);
         exp_q.push_back(fir_word(1'b1, sel));
         if (zse) exp_q.push_back(MIDSCALE);
      end
   end
   // The watching side takes the oldest note at each pop; an unexpected word always fails.
   always @(posedge clk) begin
      if (rst_n && ov === 1'b1 && ordy) begin
         if (exp_q.size() == 0) check_word(od, ~od);
         else check_word(od, exp_q.pop_front());
      end
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         close_out();
      end
   end
   initial begin
      for (int i = 0; i < HIST_LEN; i++) hist[i] = 0;
      void'($urandom(32'h3a056b94));
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      for (int m = 0; m < 4; m++) begin
         sel = m[0];
         zse = m[1];
         repeat (4) @(negedge clk);
         en = 1'b1;
         for (int k = 0; k < 120; k++) begin
            @(negedge clk);
            ordy = (k < 12) ? 1'b0 : (k < 60 ? 1'($urandom) : 1'b1);
         end
         en = 1'b0;
         for (int k = 0; k < 60 && (exp_q.size() != 0 || iv); k++) @(negedge clk);
         check_word(14'(exp_q.size()), 14'h0000);
         $display("mode %0d done", m);
      end
      close_out();
   end
endmodule
`default_nettype wire
